/* File: gprm_top.sv */
// Pin routing matrix top with classic Wishbone register slave
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module gprm_top #(
  parameter int NUM_PORTS = 4,
  localparam int NPIN = NUM_PORTS * gprm_pkg::PINS_PER_PORT
) (
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gprm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [gprm_pkg::REG_W-1:0] wb_dat_i,
  output logic [gprm_pkg::REG_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Pad side
  input wire logic [NPIN-1:0] pinIn,
  output logic [NPIN-1:0] padOut,
  output logic [NPIN-1:0] padOe,
  // Firmware and interconnect sources
  input wire logic [NPIN-1:0] fwOut,
  input wire logic [NPIN-1:0] fwOe,
  input wire logic [NPIN-1:0] dsiOut,
  input wire logic [NPIN-1:0] dsiOe,
  // Peripheral sources
  input wire logic shieldDrive,
  input wire logic lcdComDrive,
  input wire logic lcdSegDrive,
  input wire logic [NPIN-1:0] act0Out,
  input wire logic [NPIN-1:0] act0Oe,
  input wire logic [NPIN-1:0] act1Out,
  input wire logic [NPIN-1:0] act1Oe,
  input wire logic [NPIN-1:0] act2Out,
  input wire logic [NPIN-1:0] act2Oe,
  input wire logic [NPIN-1:0] ds0Out,
  input wire logic [NPIN-1:0] ds0Oe,
  input wire logic [NPIN-1:0] ds1Out,
  input wire logic [NPIN-1:0] ds1Oe,
  // Analog switch enables
  output logic [NPIN-1:0] senseEn,
  output logic [NPIN-1:0] shieldEn,
  output logic [NPIN-1:0] busAEn,
  output logic [NPIN-1:0] busBEn,
  output logic [NPIN-1:0] lcdComEn,
  output logic [NPIN-1:0] lcdSegEn,
  // Pin input fanned to the selected consumer only
  output logic [NPIN-1:0] dsiIn,
  output logic [NPIN-1:0] act0In,
  output logic [NPIN-1:0] act1In,
  output logic [NPIN-1:0] act2In,
  output logic [NPIN-1:0] ds0In,
  output logic [NPIN-1:0] ds1In
);
  localparam int RW = gprm_pkg::REG_W;
  localparam int PP = gprm_pkg::PINS_PER_PORT;
  localparam int SW = gprm_pkg::SEL_W;

  if (NUM_PORTS < 1 || NUM_PORTS > gprm_pkg::PORT_MAX) begin : g_bad_ports
    $error("gprm_top: NUM_PORTS must lie between 1 and PORT_MAX");
  end

  // Select window must end before the pin-state window starts
  if (gprm_pkg::SEL_BASE + gprm_pkg::PORT_MAX * gprm_pkg::PORT_STRIDE
      > gprm_pkg::PIN_STATE_BASE) begin : g_bad_map
    $error("gprm_top: select and pin-state windows overlap");
  end

  // Bus decode
  logic req;
  logic [gprm_pkg::ADR_W-1:0] selTop;
  logic [gprm_pkg::ADR_W-1:0] stateTop;
  logic [gprm_pkg::ADR_W-1:0] portSpan;
  logic hitSel;
  logic hitState;
  logic [gprm_pkg::ADR_W-1:0] selOff;
  logic [gprm_pkg::ADR_W-1:0] stateOff;
  logic [NUM_PORTS-1:0] wrPort;
  logic [NUM_PORTS*RW-1:0] selFlat;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign portSpan = gprm_pkg::ADR_W'(NUM_PORTS * gprm_pkg::PORT_STRIDE);
  assign selOff = wb_adr_i - gprm_pkg::SEL_BASE;
  assign stateOff = wb_adr_i - gprm_pkg::PIN_STATE_BASE;
  assign selTop = gprm_pkg::SEL_BASE + portSpan;
  assign stateTop = gprm_pkg::PIN_STATE_BASE + portSpan;
  // Only aligned words inside each window answer with data
  assign hitSel = (wb_adr_i >= gprm_pkg::SEL_BASE) && (wb_adr_i < selTop)
    && ((wb_adr_i & gprm_pkg::WORD_MASK) == '0);
  assign hitState = (wb_adr_i >= gprm_pkg::PIN_STATE_BASE)
    && (wb_adr_i < stateTop)
    && ((wb_adr_i & gprm_pkg::WORD_MASK) == '0);

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_wr
    assign wrPort[p] = req && wb_we_i && hitSel
      && (selOff[gprm_pkg::ADR_W-1:2] == (gprm_pkg::ADR_W-2)'(p));
  end

  gprm_sel_regs #(
    .NUM_PORTS(NUM_PORTS)
  ) u_regs (
    .clk(clk),
    .reset_n(reset_n),
    .wrPort(wrPort),
    .wrSel(wb_sel_i),
    .wrData(wb_dat_i),
    .selFlat(selFlat)
  );

  // Bus answer state: one wait, ack high one cycle
  logic ack_r;
  logic ack_nxt;
  logic [RW-1:0] rdata_r;
  logic [RW-1:0] rdata_nxt;
  logic [NUM_PORTS*RW-1:0] stateFlat;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_state
    assign stateFlat[p*RW +: RW] = {{(RW-PP){1'b0}}, pinIn[p*PP +: PP]};
  end

  always_comb begin
    ack_nxt = req;
    rdata_nxt = rdata_r;
    if (req && !wb_we_i) begin
      rdata_nxt = gprm_pkg::RD_ZERO;
      // Unmapped or misaligned reads still ack, with zero data
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (hitSel && selOff[gprm_pkg::ADR_W-1:2]
            == (gprm_pkg::ADR_W-2)'(p)) begin
          rdata_nxt = selFlat[p*RW +: RW];
        end
        if (hitState && stateOff[gprm_pkg::ADR_W-1:2]
            == (gprm_pkg::ADR_W-2)'(p)) begin
          rdata_nxt = stateFlat[p*RW +: RW];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdata_r <= gprm_pkg::RD_ZERO;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Routing: each pin decoded from its own nibble
  logic [NPIN-1:0] padOut_nxt;
  logic [NPIN-1:0] padOe_nxt;
  logic [NPIN-1:0] senseEn_nxt;
  logic [NPIN-1:0] shieldEn_nxt;
  logic [NPIN-1:0] busAEn_nxt;
  logic [NPIN-1:0] busBEn_nxt;
  logic [NPIN-1:0] lcdComEn_nxt;
  logic [NPIN-1:0] lcdSegEn_nxt;
  logic [NPIN-1:0] toDsi;
  logic [NPIN-1:0] toAct0;
  logic [NPIN-1:0] toAct1;
  logic [NPIN-1:0] toAct2;
  logic [NPIN-1:0] toDs0;
  logic [NPIN-1:0] toDs1;

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic [2:0] toAct;
    logic [1:0] toDs;

    gprm_pin_mux u_mux (
      .route(selFlat[i*SW +: SW]),
      .fwOut(fwOut[i]),
      .fwOe(fwOe[i]),
      .dsiOut(dsiOut[i]),
      .dsiOe(dsiOe[i]),
      .shieldDrive(shieldDrive),
      .actOut({act2Out[i], act1Out[i], act0Out[i]}),
      .actOe({act2Oe[i], act1Oe[i], act0Oe[i]}),
      .lcdComDrive(lcdComDrive),
      .lcdSegDrive(lcdSegDrive),
      .dsOut({ds1Out[i], ds0Out[i]}),
      .dsOe({ds1Oe[i], ds0Oe[i]}),
      .padOut(padOut_nxt[i]),
      .padOe(padOe_nxt[i]),
      .senseEn(senseEn_nxt[i]),
      .shieldEn(shieldEn_nxt[i]),
      .busAEn(busAEn_nxt[i]),
      .busBEn(busBEn_nxt[i]),
      .lcdComEn(lcdComEn_nxt[i]),
      .lcdSegEn(lcdSegEn_nxt[i]),
      .toDsi(toDsi[i]),
      .toAct(toAct),
      .toDs(toDs)
    );

    assign toAct0[i] = toAct[0];
    assign toAct1[i] = toAct[1];
    assign toAct2[i] = toAct[2];
    assign toDs0[i] = toDs[0];
    assign toDs1[i] = toDs[1];
  end

  // Input fan-out: a consumer sees the pin only while it owns it
  logic [NPIN-1:0] dsiIn_nxt;
  logic [NPIN-1:0] act0In_nxt;
  logic [NPIN-1:0] act1In_nxt;
  logic [NPIN-1:0] act2In_nxt;
  logic [NPIN-1:0] ds0In_nxt;
  logic [NPIN-1:0] ds1In_nxt;

  always_comb begin
    dsiIn_nxt = pinIn & toDsi;
    act0In_nxt = pinIn & toAct0;
    act1In_nxt = pinIn & toAct1;
    act2In_nxt = pinIn & toAct2;
    ds0In_nxt = pinIn & toDs0;
    ds1In_nxt = pinIn & toDs1;
  end

  // Registered outputs cost one cycle of latency on every route
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      padOut <= '0;
      padOe <= '0;
      senseEn <= '0;
      shieldEn <= '0;
      busAEn <= '0;
      busBEn <= '0;
      lcdComEn <= '0;
      lcdSegEn <= '0;
      dsiIn <= '0;
      act0In <= '0;
      act1In <= '0;
      act2In <= '0;
      ds0In <= '0;
      ds1In <= '0;
    end else begin
      padOut <= padOut_nxt;
      padOe <= padOe_nxt;
      senseEn <= senseEn_nxt;
      shieldEn <= shieldEn_nxt;
      busAEn <= busAEn_nxt;
      busBEn <= busBEn_nxt;
      lcdComEn <= lcdComEn_nxt;
      lcdSegEn <= lcdSegEn_nxt;
      dsiIn <= dsiIn_nxt;
      act0In <= act0In_nxt;
      act1In <= act1In_nxt;
      act2In <= act2In_nxt;
      ds0In <= ds0In_nxt;
      ds1In <= ds1In_nxt;
    end
  end
endmodule : gprm_top

/* File: gprm_pkg.sv */
// Constants for the pin routing matrix
// What this block does
// - One 32-bit select register per port
// - Each pin owns a 4-bit field
// - Pins routed to internal peripheral resources
// - 0 firmware; 1 firmware out, interconnect enable
// - 2 interconnect both; 3 interconnect out, firmware enable
// - 4 connects capacitive sense electrode
// - 5 connects capacitive shield electrode
// - 6 connects analog bus A
// - 7 connects analog bus B
// - 8..10 active functions; 11 reserved
// - 12 drives LCD common
// - 13 drives LCD segment
// - 14, 15 select deep-sleep functions
package gprm_pkg;
  localparam int REG_W = 32;
  localparam int SEL_W = 4;
  localparam int PINS_PER_PORT = REG_W / SEL_W;
  localparam int PORT_MAX = 8;
  localparam int ADR_W = 8;

  localparam logic [REG_W-1:0] SEL_RESET = 32'h0000_0000;
  localparam logic [REG_W-1:0] RD_ZERO = 32'h0000_0000;

  // Byte addresses on the register bus
  localparam logic [ADR_W-1:0] SEL_BASE = 8'h00;
  localparam logic [ADR_W-1:0] PIN_STATE_BASE = 8'h40;
  localparam logic [ADR_W-1:0] PORT_STRIDE = 8'h04;
  localparam logic [ADR_W-1:0] WORD_MASK = 8'h03;

  // Routing codes held in each pin field
  localparam logic [SEL_W-1:0] ROUTE_FW = 4'h0;
  localparam logic [SEL_W-1:0] ROUTE_FW_OUT_DSI_OE = 4'h1;
  localparam logic [SEL_W-1:0] ROUTE_DSI = 4'h2;
  localparam logic [SEL_W-1:0] ROUTE_DSI_OUT_FW_OE = 4'h3;
  localparam logic [SEL_W-1:0] ROUTE_SENSE = 4'h4;
  localparam logic [SEL_W-1:0] ROUTE_SHIELD = 4'h5;
  localparam logic [SEL_W-1:0] ROUTE_BUS_A = 4'h6;
  localparam logic [SEL_W-1:0] ROUTE_BUS_B = 4'h7;
  localparam logic [SEL_W-1:0] ROUTE_ACT0 = 4'h8;
  localparam logic [SEL_W-1:0] ROUTE_ACT1 = 4'h9;
  localparam logic [SEL_W-1:0] ROUTE_ACT2 = 4'ha;
  localparam logic [SEL_W-1:0] ROUTE_RSVD = 4'hb;
  localparam logic [SEL_W-1:0] ROUTE_LCD_COM = 4'hc;
  localparam logic [SEL_W-1:0] ROUTE_LCD_SEG = 4'hd;
  localparam logic [SEL_W-1:0] ROUTE_DS0 = 4'he;
  localparam logic [SEL_W-1:0] ROUTE_DS1 = 4'hf;
endpackage : gprm_pkg

/* File: gprm_pin_mux.sv */
// Per-pin routing switch, purely combinational
`timescale 1ns/100ps
module gprm_pin_mux (
  input wire logic [gprm_pkg::SEL_W-1:0] route,
  input wire logic fwOut,
  input wire logic fwOe,
  input wire logic dsiOut,
  input wire logic dsiOe,
  input wire logic shieldDrive,
  input wire logic [2:0] actOut,
  input wire logic [2:0] actOe,
  input wire logic lcdComDrive,
  input wire logic lcdSegDrive,
  input wire logic [1:0] dsOut,
  input wire logic [1:0] dsOe,
  output logic padOut,
  output logic padOe,
  output logic senseEn,
  output logic shieldEn,
  output logic busAEn,
  output logic busBEn,
  output logic lcdComEn,
  output logic lcdSegEn,
  output logic toDsi,
  output logic [2:0] toAct,
  output logic [1:0] toDs
);
  always_comb begin
    padOut = 1'b0;
    padOe = 1'b0;
    senseEn = 1'b0;
    shieldEn = 1'b0;
    busAEn = 1'b0;
    busBEn = 1'b0;
    lcdComEn = 1'b0;
    lcdSegEn = 1'b0;
    toDsi = 1'b0;
    toAct = 3'h0;
    toDs = 2'h0;
    unique case (route)
      gprm_pkg::ROUTE_FW: begin
        padOut = fwOut;
        padOe = fwOe;
      end
      gprm_pkg::ROUTE_FW_OUT_DSI_OE: begin
        padOut = fwOut;
        padOe = dsiOe;
        toDsi = 1'b1;
      end
      gprm_pkg::ROUTE_DSI: begin
        padOut = dsiOut;
        padOe = dsiOe;
        toDsi = 1'b1;
      end
      gprm_pkg::ROUTE_DSI_OUT_FW_OE: begin
        padOut = dsiOut;
        padOe = fwOe;
        toDsi = 1'b1;
      end
      gprm_pkg::ROUTE_SENSE: senseEn = 1'b1;
      gprm_pkg::ROUTE_SHIELD: begin
        shieldEn = 1'b1;
        padOut = shieldDrive;
        padOe = 1'b1;
      end
      gprm_pkg::ROUTE_BUS_A: busAEn = 1'b1;
      gprm_pkg::ROUTE_BUS_B: busBEn = 1'b1;
      gprm_pkg::ROUTE_ACT0: begin
        padOut = actOut[0];
        padOe = actOe[0];
        toAct = 3'h1;
      end
      gprm_pkg::ROUTE_ACT1: begin
        padOut = actOut[1];
        padOe = actOe[1];
        toAct = 3'h2;
      end
      gprm_pkg::ROUTE_ACT2: begin
        padOut = actOut[2];
        padOe = actOe[2];
        toAct = 3'h4;
      end
      // Reserved code leaves the pin floating and unconnected
      gprm_pkg::ROUTE_RSVD: padOe = 1'b0;
      gprm_pkg::ROUTE_LCD_COM: begin
        lcdComEn = 1'b1;
        padOut = lcdComDrive;
        padOe = 1'b1;
      end
      gprm_pkg::ROUTE_LCD_SEG: begin
        lcdSegEn = 1'b1;
        padOut = lcdSegDrive;
        padOe = 1'b1;
      end
      gprm_pkg::ROUTE_DS0: begin
        padOut = dsOut[0];
        padOe = dsOe[0];
        toDs = 2'h1;
      end
      gprm_pkg::ROUTE_DS1: begin
        padOut = dsOut[1];
        padOe = dsOe[1];
        toDs = 2'h2;
      end
    endcase
  end
endmodule : gprm_pin_mux

/* File: gprm_sel_regs.sv */
// Bank of per-port routing select registers
`timescale 1ns/100ps
module gprm_sel_regs #(
  parameter int NUM_PORTS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [NUM_PORTS-1:0] wrPort,
  input wire logic [3:0] wrSel,
  input wire logic [gprm_pkg::REG_W-1:0] wrData,
  output logic [NUM_PORTS*gprm_pkg::REG_W-1:0] selFlat
);
  if (NUM_PORTS < 1) begin : g_bad_ports
    $error("gprm_sel_regs: NUM_PORTS must be at least 1");
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [gprm_pkg::REG_W-1:0] sel_r;
    logic [gprm_pkg::REG_W-1:0] sel_nxt;

    always_comb begin
      sel_nxt = sel_r;
      for (int b = 0; b < 4; b++) begin
        if (wrPort[p] && wrSel[b]) begin
          sel_nxt[b*8 +: 8] = wrData[b*8 +: 8];
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        sel_r <= gprm_pkg::SEL_RESET;
      end else begin
        sel_r <= sel_nxt;
      end
    end

    assign selFlat[p*gprm_pkg::REG_W +: gprm_pkg::REG_W] = sel_r;
  end
endmodule : gprm_sel_regs

/* File: gprm_top_properties.sv */
// Port-level properties of the pin routing matrix
`timescale 1ns/100ps
module gprm_checker #(
  parameter int NUM_PORTS = 4,
  localparam int NPIN = NUM_PORTS * gprm_pkg::PINS_PER_PORT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [NPIN-1:0] pinIn,
  input wire logic [NPIN-1:0] padOut,
  input wire logic [NPIN-1:0] padOe,
  input wire logic [NPIN-1:0] fwOut,
  input wire logic [NPIN-1:0] fwOe,
  input wire logic shieldDrive,
  input wire logic lcdComDrive,
  input wire logic lcdSegDrive,
  input wire logic [NPIN-1:0] senseEn,
  input wire logic [NPIN-1:0] shieldEn,
  input wire logic [NPIN-1:0] busAEn,
  input wire logic [NPIN-1:0] busBEn,
  input wire logic [NPIN-1:0] lcdComEn,
  input wire logic [NPIN-1:0] lcdSegEn,
  input wire logic [NPIN-1:0] dsiIn,
  input wire logic [NPIN-1:0] act0In
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sAckPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_PULSE: assert property (sReq |=> sAckPulse)
    else $error("ack not one pulse one cycle after request");
  AST_ACK_CAUSE: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_RESET_QUIET: assert property ($rose(reset_n) |-> !wb_ack_o &&
    padOe == '0 && (senseEn | shieldEn | busAEn | lcdSegEn) == '0)
    else $error("outputs not cleared by reset");
  AST_FW_AFTER_RESET: assert property ($rose(reset_n) |=>
    padOut == $past(fwOut) && padOe == $past(fwOe))
    else $error("pins not under firmware after reset");
  AST_SHIELD_DRIVE: assert property (shieldEn != '0 |->
    ((shieldEn & ~padOe) | (shieldEn & (padOut ^ {NPIN{$past(shieldDrive)}})))
    == '0) else $error("shield pin not driven with shield wave");
  AST_LCD_DRIVE: assert property (
    ((lcdComEn & (padOut ^ {NPIN{$past(lcdComDrive)}})) |
    (lcdSegEn & (padOut ^ {NPIN{$past(lcdSegDrive)}})) |
    ((lcdComEn | lcdSegEn) & ~padOe)) == '0)
    else $error("lcd pin not driven with its wave");
  AST_ANALOG_FLOAT: assert property (
    ((senseEn | busAEn | busBEn) & padOe) == '0)
    else $error("analog route drives its pad");
  AST_ONE_ROUTE: assert property (((senseEn & (shieldEn | busAEn)) |
    (busAEn & busBEn) | (lcdComEn & lcdSegEn) | (dsiIn & act0In)) == '0)
    else $error("pin routed two ways at once");
  AST_INPUT_GATED: assert property (
    ((dsiIn | act0In) & ~$past(pinIn)) == '0)
    else $error("consumer input not taken from pin");
endmodule : gprm_checker

/* File: gprm_pad_model.sv */
// Pad model: driven pads read back, floating ones wander
`timescale 1ns/100ps
module gprm_pad_model #(
  parameter int NPIN = 32
) (
  input wire logic clk,
  input wire logic [NPIN-1:0] padOut,
  input wire logic [NPIN-1:0] padOe,
  output logic [NPIN-1:0] pinIn
);
  // No pull on these pads, so a floating pin must not hold its last level
  logic [NPIN-1:0] floatLvl_r = {(NPIN/2){2'h1}};
  always @(posedge clk) begin
    floatLvl_r <= ~floatLvl_r;
  end
  assign pinIn = (padOe & padOut) | (~padOe & floatLvl_r);
endmodule : gprm_pad_model

/* File: gprm_top_tb.sv */
// Self-checking bench for the pin routing matrix
`timescale 1ns/100ps
module gprm_top_tb;
  localparam int NP = 4;
  localparam int NPIN = NP * gprm_pkg::PINS_PER_PORT;
  localparam int EW = 14 * NPIN;
  typedef struct {
    logic [EW-1:0] e;
    logic [EW-1:0] m;
  } gprm_exp_s;
  logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic shieldDrive, lcdComDrive, lcdSegDrive;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [NPIN-1:0] src [14];
  logic [NPIN-1:0] pinIn, padOut, padOe, senseEn, shieldEn, busAEn, busBEn;
  logic [NPIN-1:0] lcdComEn, lcdSegEn, dsiIn, act0In, act1In, act2In;
  logic [NPIN-1:0] ds0In, ds1In;
  logic [31:0] sh [NP];
  logic [31:0] rng = 32'h24c3ae63;
  logic [31:0] rdQ [$];
  gprm_exp_s rtQ [$];
  int miscompares = 0;
  int testsRun = 0;

  gprm_top #(.NUM_PORTS(NP)) u_dut (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pinIn(pinIn), .padOut(padOut), .padOe(padOe),
    .fwOut(src[0]), .fwOe(src[1]), .dsiOut(src[2]), .dsiOe(src[3]),
    .shieldDrive(shieldDrive), .lcdComDrive(lcdComDrive),
    .lcdSegDrive(lcdSegDrive), .act0Out(src[4]), .act0Oe(src[5]),
    .act1Out(src[6]), .act1Oe(src[7]), .act2Out(src[8]), .act2Oe(src[9]),
    .ds0Out(src[10]), .ds0Oe(src[11]), .ds1Out(src[12]), .ds1Oe(src[13]),
    .senseEn(senseEn), .shieldEn(shieldEn), .busAEn(busAEn), .busBEn(busBEn),
    .lcdComEn(lcdComEn), .lcdSegEn(lcdSegEn), .dsiIn(dsiIn), .act0In(act0In),
    .act1In(act1In), .act2In(act2In), .ds0In(ds0In), .ds1In(ds1In)
  );
  gprm_pad_model #(.NPIN(NPIN)) u_pads (
    .clk(clk), .padOut(padOut), .padOe(padOe), .pinIn(pinIn)
  );

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd

  task automatic giveVerdict();
    if (miscompares == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : giveVerdict

  task automatic busCycle(input logic we, input logic [7:0] adr,
      input logic [31:0] dat, input logic [3:0] sel);
    int i;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'h1) break;
    end
    if (i == 16) begin
      miscompares++;
      giveVerdict();
    end
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk);
  endtask : busCycle

  task automatic wr(input int p, input logic [31:0] d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) sh[p][8*b+:8] = d[8*b+:8];
    end
    busCycle(1'h1, 8'(4*p), d, s);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rdQ.push_back(x);
    busCycle(1'h0, a, 32'h0, 4'hf);
  endtask : rd

  // Expected pin state is worked out between edges, once inputs settle
  task automatic route(input int n);
    gprm_exp_s x;
    logic [13:0] v;
    logic [3:0] c;
    repeat (n) begin
      @(posedge clk);
      foreach (src[k]) src[k] <= rnd();
      {shieldDrive, lcdComDrive, lcdSegDrive} <= 3'(rnd());
      @(negedge clk);
      for (int i = 0; i < NPIN; i++) begin
        c = sh[i/8][4*(i%8)+:4];
        v = 14'h0;
        case (c)
          4'h0: v[13:12] = {src[0][i], src[1][i]};
          4'h1: v[13:12] = {src[0][i], src[3][i]};
          4'h2: v[13:12] = {src[2][i], src[3][i]};
          4'h3: v[13:12] = {src[2][i], src[1][i]};
          4'h4: v[11] = 1'h1;
          4'h5: v[13:10] = {shieldDrive, 3'h5};
          4'h6: v[9] = 1'h1;
          4'h7: v[8] = 1'h1;
          4'h8, 4'h9, 4'ha: begin
            v[13:12] = {src[2*c-12][i], src[2*c-11][i]};
            v[12-c] = pinIn[i];
          end
          4'hc: v[13:7] = {lcdComDrive, 6'h21};
          4'hd: v[13:6] = {lcdSegDrive, 7'h41};
          4'he, 4'hf: begin
            v[13:12] = {src[2*c-18][i], src[2*c-17][i]};
            v[15-c] = pinIn[i];
          end
          default: ;
        endcase
        if (c inside {4'h1, 4'h2, 4'h3}) v[5] = pinIn[i];
        x.e[14*i+:14] = v;
        x.m[14*i+:14] = {!(c inside {4'h4, 4'h6, 4'h7, 4'hb}), 13'h1fff};
      end
      rtQ.push_back(x);
    end
    @(posedge clk);
  endtask : route

  always begin
    logic [EW-1:0] act;
    gprm_exp_s x;
    logic [31:0] rx;
    @(posedge clk);
    #1;
    if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) begin
      rx = (rdQ.size() > 0) ? rdQ.pop_front() : ~wb_dat_o;
      testsRun++;
      if (wb_dat_o !== rx) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, wb_dat_o, rx);
      end
    end
    if (rtQ.size() > 0) begin
      x = rtQ.pop_front();
      for (int i = 0; i < NPIN; i++) begin
        act[14*i+:14] = {padOut[i], padOe[i], senseEn[i], shieldEn[i],
          busAEn[i], busBEn[i], lcdComEn[i], lcdSegEn[i], dsiIn[i],
          act0In[i], act1In[i], act2In[i], ds0In[i], ds1In[i]};
      end
      testsRun++;
      if (((act ^ x.e) & x.m) !== '0) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, act, x.e);
      end
    end
  end

  initial begin
    reset_n = 1'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {shieldDrive, lcdComDrive, lcdSegDrive} = 3'h0;
    foreach (src[k]) src[k] = '0;
    foreach (sh[p]) sh[p] = 32'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    for (int p = 0; p < NP; p++) rd(8'(4*p), 32'h0);
    wr(0, 32'h76543210, 4'hf);
    wr(1, 32'hfedcba98, 4'hf);
    wr(2, rnd(), 4'hf);
    wr(3, rnd(), 4'hf);
    route(40);
    wr(2, 32'hffffffff, 4'h2);
    rd(8'h08, sh[2]);
    busCycle(1'h1, 8'h80, 32'hffffffff, 4'hf);
    rd(8'h80, 32'h0);
    rd(8'h01, 32'h0);
    busCycle(1'h1, 8'h40, 32'hffffffff, 4'hf);
    rd(8'h00, sh[0]);
    repeat (6) begin
      for (int p = 0; p < NP; p++) begin
        wr(p, rnd(), 4'(rnd()));
        rd(8'(4*p), sh[p]);
      end
      route(20);
    end
    // Second reset in mid-run must drop every route back to firmware
    reset_n <= 1'h0;
    // All enables high so every pad reads back its firmware level
    src[1] <= '1;
    repeat (2) @(posedge clk);
    foreach (sh[p]) sh[p] = 32'h0;
    reset_n <= 1'h1;
    @(posedge clk);
    rd(8'h04, 32'h0);
    rd(8'h40, {24'h0, src[0][7:0]});
    rd(8'h4c, {24'h0, src[0][31:24]});
    route(5);
    giveVerdict();
  end
endmodule : gprm_top_tb

bind gprm_top gprm_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pinIn(pinIn), .padOut(padOut), .padOe(padOe),
  .fwOut(fwOut), .fwOe(fwOe), .shieldDrive(shieldDrive),
  .lcdComDrive(lcdComDrive), .lcdSegDrive(lcdSegDrive), .senseEn(senseEn),
  .shieldEn(shieldEn), .busAEn(busAEn), .busBEn(busBEn),
  .lcdComEn(lcdComEn), .lcdSegEn(lcdSegEn), .dsiIn(dsiIn), .act0In(act0In)
);
